// ===== verilog/dsctl_pkg.sv
// Operation
// - forward symbol carries 35 bits: pixels, syncs, control, gpio, audio
// - pixel clock 25-96 MHz single lane, 50-170 MHz dual lane
// - back frames carry control, crc, four gpio and four second-link gpio bits at 5 or 20 Mbps
// - port select bits 1:0 steer accesses to duplicated register sets
// - common registers reachable regardless of port select
// - duplicated read returns selected copy; both set returns port 1
// - duplicated write updates every selected port copy
// - power down low tri-states lock, link check, data, gpio, csi
// - before lock, lock output low or tri-state per output enable
// - on lock drive lock high unless enable set with select low or input static; enable, select set and input active give valid outputs
// - enable clear: select low drives low and hs zero, high tri-states
// - enable set, static or select low: lock, data low, csi hs zero
// - active-low remote interrupt forwarded over link when enabled
// - gpio nibble 0x5 makes forward-channel output from serializer state
// - gpio nibble 0x3 makes back-channel input sent to serializer
// - gpio config registers reach primary or second-link gpio by select
// - second-link gpio works only in dual-lane mode
// - legacy serializer sets 18-bit mode; deserializer adopts it from link
package dsctl_pkg;

  // ***************
  // register map (index, byte address is four times it)
  // ***************
  localparam logic [7:0] OUT_CFG_IDX   = 8'h02;
  localparam logic [7:0] GPIO0_CFG_IDX = 8'h1d;
  localparam logic [7:0] GPIO21_CFG_IDX = 8'h1e;
  localparam logic [7:0] GPIO3_CFG_IDX = 8'h1f;
  localparam logic [7:0] PORT_SEL_IDX  = 8'h34;
  localparam logic [7:0] CTRL_IDX      = 8'h35;
  localparam logic [7:0] STATUS_IDX    = 8'h36;

  // ***************
  // fields and reset values
  // ***************
  localparam int OUT_EN_BIT    = 7;
  localparam int SLEEP_SEL_BIT = 4;
  localparam int IRQ_FWD_BIT   = 0;
  localparam logic [7:0] OUT_CFG_RST  = 8'h90;
  localparam logic [7:0] PORT_SEL_RST = 8'h01;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [3:0] GPIO_CFG_RST = 4'h0;
  localparam logic [3:0] GPIO_FWD_OUT = 4'h5;
  localparam logic [3:0] GPIO_BC_IN   = 4'h3;
  localparam logic [3:0] GPIO_LOC_LO  = 4'h1;
  localparam logic [3:0] GPIO_LOC_HI  = 4'h9;

  // ***************
  // pixel clock limits in MHz
  // ***************
  localparam logic [7:0] PIX_MIN_1L = 8'd25;
  localparam logic [7:0] PIX_MAX_1L = 8'd96;
  localparam logic [7:0] PIX_MIN_2L = 8'd50;
  localparam logic [7:0] PIX_MAX_2L = 8'd170;

  // ***************
  // back channel timing
  // ***************
  localparam int PCLK_MHZ    = 20;
  localparam int BC_SLOW_MBPS = 5;
  localparam int BC_FAST_MBPS = 20;
  localparam logic [1:0] BC_SLOW_DIV =
    2'(PCLK_MHZ / BC_SLOW_MBPS - 1);
  localparam logic [1:0] BC_FAST_DIV =
    2'(PCLK_MHZ / BC_FAST_MBPS - 1);
  localparam int BC_BITS = 21;

  typedef enum logic [1:0] {CSI_OFF, CSI_HS_ZERO, CSI_VALID} dsctl_csi_t;
  typedef enum {ST_POWER_DOWN, ST_ACQUIRE, ST_LOCKED} dsctl_state_t;

  typedef struct packed {
    logic [16:0] pixel_sync;
    logic [7:0]  ctrl;
    logic [3:0]  gpio;
    logic [3:0]  dgpio;
    logic        mode18;
    logic        audio;
  } dsctl_fwd_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] gpio;
    logic [3:0] dgpio;
    logic       irq_n;
    logic [3:0] crc;
  } dsctl_bc_t;

endpackage

// ===== verilog/dsctl_top.sv
`timescale 1ns/1ps
module dsctl_top (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link status and forward channel
  input  wire logic        power_down_n,
  input  wire logic        clock_recovery_loop,
  input  wire logic        input_active,
  input  wire logic        dual_lane,
  input  wire logic [7:0]  pix_freq_mhz,
  input  wire logic        link_check_ok,
  input  wire logic        fwd_valid,
  input  wire dsctl_pkg::dsctl_fwd_t fwd_symbol,
  // back channel
  input  wire logic        strap_select_1,
  input  wire logic [7:0]  bc_ctrl_in,
  output logic             bc_data,
  output logic             bc_start,
  output logic             bc_bit_en,
  // status outputs
  output logic             lock_out,
  output logic             lock_oe,
  output logic             pass_out,
  output logic             pass_oe,
  output logic             data_en,
  output logic             data_oe,
  output dsctl_pkg::dsctl_csi_t csi_state,
  output logic             mode18,
  // gpio pins
  input  wire logic        remote_irq_in_n,
  input  wire logic [3:0]  gpio_in,
  output logic      [3:0]  gpio_out,
  output logic      [3:0]  gpio_oe,
  input  wire logic [3:0]  dgpio_in,
  output logic      [3:0]  dgpio_out,
  output logic      [3:0]  dgpio_oe
);

  // ***************
  // registers
  // ***************
  logic [7:0] out_cfg_reg;
  logic [7:0] port_sel_reg;
  logic [7:0] ctrl_reg;
  logic [3:0] gcfg_reg [2][4];
  logic [7:0] idx;
  logic       wr_acc;
  logic       rd_setup;
  logic       mapped;
  logic       locked;
  logic       rate_ok;
  logic [3:0] fwd_gpio_reg;
  logic [3:0] fwd_dgpio_reg;
  logic [3:0] gpio_s1, gpio_s2, dgpio_s1, dgpio_s2;
  logic       irq_s1, irq_s2;
  dsctl_pkg::dsctl_state_t state_reg;
  dsctl_pkg::dsctl_bc_t    bc_next;
  logic [dsctl_pkg::BC_BITS-1:0] bc_shift_reg;
  logic [4:0] bc_cnt_reg;
  logic [1:0] div_reg;
  logic [1:0] div_max;
  logic       oe_bit, sel_bit;

  assign idx    = paddr[9:2];
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;
  assign oe_bit  = out_cfg_reg[dsctl_pkg::OUT_EN_BIT];
  assign sel_bit = out_cfg_reg[dsctl_pkg::SLEEP_SEL_BIT];

  always_comb begin
    case (idx)
      dsctl_pkg::OUT_CFG_IDX, dsctl_pkg::GPIO0_CFG_IDX,
      dsctl_pkg::GPIO21_CFG_IDX, dsctl_pkg::GPIO3_CFG_IDX,
      dsctl_pkg::PORT_SEL_IDX, dsctl_pkg::CTRL_IDX,
      dsctl_pkg::STATUS_IDX: mapped = (paddr[1:0] == 2'h0);
      default:               mapped = 1'b0;
    endcase
  end

  // common registers, independent of port select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_cfg_reg  <= dsctl_pkg::OUT_CFG_RST;
      port_sel_reg <= dsctl_pkg::PORT_SEL_RST;
      ctrl_reg     <= dsctl_pkg::CTRL_RST;
    end else if (wr_acc) begin
      case (idx)
        dsctl_pkg::OUT_CFG_IDX:  out_cfg_reg  <= pwdata[7:0];
        dsctl_pkg::PORT_SEL_IDX: port_sel_reg <= pwdata[7:0];
        dsctl_pkg::CTRL_IDX:     ctrl_reg     <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // duplicated gpio config, one copy per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    for (genvar g = 0; g < 4; g++) begin : g_nib
      localparam logic [7:0] NIDX = (g == 0) ? dsctl_pkg::GPIO0_CFG_IDX :
                                    (g == 3) ? dsctl_pkg::GPIO3_CFG_IDX :
                                    dsctl_pkg::GPIO21_CFG_IDX;
      localparam int LSB = (g == 2) ? 4 : 0;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gcfg_reg[p][g] <= dsctl_pkg::GPIO_CFG_RST;
        end else if (wr_acc && idx == NIDX && port_sel_reg[p]) begin
          gcfg_reg[p][g] <= pwdata[LSB +: 4];
        end
      end
    end
  end

  // apb answer, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        pslverr <= !mapped;
        prdata  <= 32'h0000_0000;
        if (mapped) begin
          case (idx)
            dsctl_pkg::OUT_CFG_IDX:  prdata[7:0] <= out_cfg_reg;
            dsctl_pkg::PORT_SEL_IDX: prdata[7:0] <= port_sel_reg;
            dsctl_pkg::CTRL_IDX:     prdata[7:0] <= ctrl_reg;
            dsctl_pkg::GPIO0_CFG_IDX:
              prdata[3:0] <= gcfg_reg[port_sel_reg[1]][0];
            dsctl_pkg::GPIO21_CFG_IDX:
              prdata[7:0] <= {gcfg_reg[port_sel_reg[1]][2],
                              gcfg_reg[port_sel_reg[1]][1]};
            dsctl_pkg::GPIO3_CFG_IDX:
              prdata[3:0] <= gcfg_reg[port_sel_reg[1]][3];
            dsctl_pkg::STATUS_IDX:
              prdata[7:0] <= {irq_s2, mode18, rate_ok, locked,
                              port_sel_reg[1] ? dgpio_s2 : gpio_s2};
            default: ;
          endcase
        end
      end
    end
  end

  // ***************
  // lock and output state
  // ***************
  always_comb begin
    if (dual_lane) begin
      rate_ok = pix_freq_mhz >= dsctl_pkg::PIX_MIN_2L &&
                pix_freq_mhz <= dsctl_pkg::PIX_MAX_2L;
    end else begin
      rate_ok = pix_freq_mhz >= dsctl_pkg::PIX_MIN_1L &&
                pix_freq_mhz <= dsctl_pkg::PIX_MAX_1L;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= dsctl_pkg::ST_POWER_DOWN;
    end else if (!power_down_n) begin
      state_reg <= dsctl_pkg::ST_POWER_DOWN;
    end else begin
      case (state_reg)
        dsctl_pkg::ST_POWER_DOWN: state_reg <= dsctl_pkg::ST_ACQUIRE;
        dsctl_pkg::ST_ACQUIRE:
          if (clock_recovery_loop && rate_ok)
            state_reg <= dsctl_pkg::ST_LOCKED;
        dsctl_pkg::ST_LOCKED:
          if (!clock_recovery_loop || !rate_ok)
            state_reg <= dsctl_pkg::ST_ACQUIRE;
        default: state_reg <= dsctl_pkg::ST_POWER_DOWN;
      endcase
    end
  end

  assign locked = (state_reg == dsctl_pkg::ST_LOCKED);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_out <= 1'b0; lock_oe <= 1'b0;
      pass_out <= 1'b0; pass_oe <= 1'b0;
      data_en  <= 1'b0; data_oe <= 1'b0;
      csi_state <= dsctl_pkg::CSI_OFF;
    end else if (state_reg == dsctl_pkg::ST_POWER_DOWN) begin
      lock_oe <= 1'b0; pass_oe <= 1'b0;
      data_oe <= 1'b0; data_en <= 1'b0;
      lock_out <= 1'b0;
      csi_state <= dsctl_pkg::CSI_OFF;
    end else if (!oe_bit) begin
      lock_out <= locked;
      lock_oe  <= locked;
      pass_out <= 1'b0;
      data_en  <= 1'b0;
      pass_oe  <= !sel_bit;
      data_oe  <= !sel_bit;
      csi_state <= sel_bit ? dsctl_pkg::CSI_OFF : dsctl_pkg::CSI_HS_ZERO;
    end else begin
      lock_oe <= 1'b1; pass_oe <= 1'b1; data_oe <= 1'b1;
      if (locked && input_active && sel_bit) begin
        lock_out <= 1'b1;
        pass_out <= link_check_ok;
        data_en  <= 1'b1;
        csi_state <= dsctl_pkg::CSI_VALID;
      end else begin
        lock_out <= 1'b0;
        data_en  <= 1'b0;
        csi_state <= dsctl_pkg::CSI_HS_ZERO;
        if (!(sel_bit && !(locked && input_active)))
          pass_out <= 1'b0;
      end
    end
  end

  // ***************
  // forward channel gpio and mode
  // ***************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_gpio_reg  <= 4'h0;
      fwd_dgpio_reg <= 4'h0;
      mode18        <= 1'b0;
    end else if (fwd_valid && locked) begin
      fwd_gpio_reg  <= fwd_symbol.gpio;
      fwd_dgpio_reg <= fwd_symbol.dgpio;
      mode18        <= fwd_symbol.mode18;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_s1 <= 4'h0; gpio_s2 <= 4'h0;
      dgpio_s1 <= 4'h0; dgpio_s2 <= 4'h0;
      irq_s1 <= 1'b1; irq_s2 <= 1'b1;
    end else begin
      gpio_s1 <= gpio_in;
      gpio_s2 <= gpio_s1;
      dgpio_s1 <= dgpio_in;
      dgpio_s2 <= dgpio_s1;
      irq_s1 <= remote_irq_in_n;
      irq_s2 <= irq_s1;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gpio_out[g] <= 1'b0; gpio_oe[g] <= 1'b0;
        dgpio_out[g] <= 1'b0; dgpio_oe[g] <= 1'b0;
      end else if (state_reg == dsctl_pkg::ST_POWER_DOWN) begin
        gpio_oe[g] <= 1'b0;
        dgpio_oe[g] <= 1'b0;
      end else begin
        case (gcfg_reg[0][g])
          dsctl_pkg::GPIO_FWD_OUT: begin
            gpio_out[g] <= fwd_gpio_reg[g];
            gpio_oe[g]  <= 1'b1;
          end
          dsctl_pkg::GPIO_LOC_LO: begin
            gpio_out[g] <= 1'b0; gpio_oe[g] <= 1'b1;
          end
          dsctl_pkg::GPIO_LOC_HI: begin
            gpio_out[g] <= 1'b1; gpio_oe[g] <= 1'b1;
          end
          default: gpio_oe[g] <= 1'b0;
        endcase
        if (dual_lane && gcfg_reg[1][g] == dsctl_pkg::GPIO_FWD_OUT) begin
          dgpio_out[g] <= fwd_dgpio_reg[g];
          dgpio_oe[g]  <= 1'b1;
        end else begin
          dgpio_oe[g] <= 1'b0;
        end
      end
    end
  end

  // ***************
  // back channel frames
  // ***************
  function automatic logic [3:0] crc_fold(input logic [16:0] d);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < 17; k++) begin
      c[k % 4] = c[k % 4] ^ d[k];
    end
    return c;
  endfunction

  always_comb begin
    bc_next.ctrl = bc_ctrl_in;
    for (int g = 0; g < 4; g++) begin
      bc_next.gpio[g] = gcfg_reg[0][g] == dsctl_pkg::GPIO_BC_IN &&
                        gpio_s2[g];
      bc_next.dgpio[g] = dual_lane &&
                         gcfg_reg[1][g] == dsctl_pkg::GPIO_BC_IN &&
                         dgpio_s2[g];
    end
    bc_next.irq_n = !ctrl_reg[dsctl_pkg::IRQ_FWD_BIT] || irq_s2;
    bc_next.crc = crc_fold({bc_next.ctrl, bc_next.gpio, bc_next.dgpio,
                            bc_next.irq_n});
  end

  assign div_max = strap_select_1 ? dsctl_pkg::BC_FAST_DIV
                                  : dsctl_pkg::BC_SLOW_DIV;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg   <= 2'h0;
      bc_bit_en <= 1'b0;
    end else if (!locked || div_reg >= div_max) begin
      div_reg   <= 2'h0;
      bc_bit_en <= locked;
    end else begin
      div_reg   <= div_reg + 2'h1;
      bc_bit_en <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_shift_reg <= '0;
      bc_cnt_reg   <= 5'h0;
      bc_data      <= 1'b0;
      bc_start     <= 1'b0;
    end else if (!locked) begin
      bc_cnt_reg <= 5'h0;
      bc_data    <= 1'b0;
      bc_start   <= 1'b0;
    end else if (bc_bit_en) begin
      if (bc_cnt_reg == 5'h0) begin
        bc_shift_reg <= bc_next;
        bc_data      <= bc_next[dsctl_pkg::BC_BITS-1];
        bc_start     <= 1'b1;
      end else begin
        bc_data  <= bc_shift_reg[dsctl_pkg::BC_BITS-1 -
                                 int'(bc_cnt_reg)];
        bc_start <= 1'b0;
      end
      bc_cnt_reg <= (bc_cnt_reg == 5'(dsctl_pkg::BC_BITS - 1)) ? 5'h0
                    : bc_cnt_reg + 5'h1;
    end else begin
      bc_start <= 1'b0;
    end
  end

  // ***************
  // assertions
  // ***************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pd_tristate_a: assert property (
    !power_down_n |=> ##1 (!lock_oe && !pass_oe && !data_oe &&
                           gpio_oe == 4'h0))
    else $error("outputs not tri-stated in power down");

  lock_high_a: assert property (
    locked && power_down_n && oe_bit && sel_bit && input_active
    |=> lock_out && csi_state == dsctl_pkg::CSI_VALID)
    else $error("lock not driven high when locked");

  lose_lock_a: assert property (
    locked && power_down_n && !clock_recovery_loop |=> ##1 !lock_out)
    else $error("lock output held after loss of lock");

  sleep_tri_a: assert property (
    state_reg != dsctl_pkg::ST_POWER_DOWN && !oe_bit && sel_bit
    |=> !data_oe && !pass_oe)
    else $error("sleep select high did not tri-state");

  static_low_a: assert property (
    state_reg != dsctl_pkg::ST_POWER_DOWN && oe_bit && !sel_bit
    |=> !lock_out && !data_en && csi_state == dsctl_pkg::CSI_HS_ZERO)
    else $error("static row not driven low");

  dup_write_a: assert property (
    wr_acc && idx == dsctl_pkg::GPIO21_CFG_IDX && port_sel_reg[1:0] == 2'h3
    |=> {gcfg_reg[0][2], gcfg_reg[0][1]} == $past(pwdata[7:0]) &&
        {gcfg_reg[1][2], gcfg_reg[1][1]} == $past(pwdata[7:0]))
    else $error("dual select write missed a copy");

  fwd_gpio_a: assert property (
    power_down_n && state_reg != dsctl_pkg::ST_POWER_DOWN &&
    gcfg_reg[0][0] == dsctl_pkg::GPIO_FWD_OUT
    |=> gpio_oe[0] && gpio_out[0] == $past(fwd_gpio_reg[0]))
    else $error("forward gpio not driven");

  irq_fwd_a: assert property (
    locked && bc_bit_en && bc_cnt_reg == 5'h0 &&
    ctrl_reg[dsctl_pkg::IRQ_FWD_BIT] && !irq_s2 |=> !bc_shift_reg[4])
    else $error("remote interrupt not forwarded");

  bc_rate_a: assert property (
    bc_bit_en && !strap_select_1 && locked |=> !bc_bit_en [*3])
    else $error("slow back channel rate wrong");

  dlane_gate_a: assert property (
    !dual_lane |=> dgpio_oe == 4'h0)
    else $error("second link gpio driven in single lane");

endmodule  // dsctl_top

// ===== bench/dsctl_ser_model.sv
`timescale 1ns/1ps
module dsctl_ser_model (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // serializer settings and host side
  input  wire logic [7:0]            irq_cfg,
  input  wire logic [3:0]            gpio_src,
  input  wire logic                  isr_rd,
  // link
  output logic                       fwd_valid,
  output dsctl_pkg::dsctl_fwd_t      fwd_symbol,
  input  wire logic                  bc_data,
  input  wire logic                  bc_start,
  input  wire logic                  bc_bit_en,
  // decoded back channel
  output dsctl_pkg::dsctl_bc_t       frame,
  output logic                       frame_done,
  output logic                       serializer_irq_out_n
);
  logic [2:0]            tick_reg;
  logic                  en_d_reg;
  logic [20:0]           sh_reg;
  logic [4:0]            cnt_reg;
  logic                  irq_prev_reg;
  logic [20:0]           sh_next;
  logic [4:0]            cnt_next;
  dsctl_pkg::dsctl_fwd_t sym;

  // ***************
  // forward symbols, one in eight cycles; junk on the bus between
  // ***************
  always_comb begin
    sym = '0;
    sym.pixel_sync = {tick_reg, 14'h2a5};
    sym.gpio = gpio_src;
    sym.dgpio = ~gpio_src;
    sym.mode18 = 1'b1;
    fwd_symbol = fwd_valid ? sym : ~sym;
    sh_next = bc_start ? {20'h0, bc_data} : {sh_reg[19:0], bc_data};
    cnt_next = bc_start ? 5'd1 : cnt_reg + 5'd1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg  <= 3'h0;
      fwd_valid <= 1'b0;
    end else begin
      tick_reg  <= tick_reg + 3'h1;
      fwd_valid <= (tick_reg == 3'h7);
    end
  end

  // ***************
  // back frame capture, bit valid one cycle after its enable
  // ***************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_reg   <= 1'b0;
      sh_reg     <= '0;
      cnt_reg    <= '0;
      frame      <= '0;
      frame_done <= 1'b0;
    end else begin
      en_d_reg   <= bc_bit_en;
      frame_done <= 1'b0;
      if (en_d_reg) begin
        sh_reg  <= sh_next;
        cnt_reg <= cnt_next;
        if (cnt_next == 5'd21) begin
          frame      <= sh_next;
          frame_done <= 1'b1;
        end
      end
    end
  end

  // ***************
  // interrupt pin: set on a new falling level, cleared by status read
  // ***************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_prev_reg         <= 1'b1;
      serializer_irq_out_n <= 1'b1;
    end else begin
      if (frame_done) begin
        irq_prev_reg <= frame.irq_n;
        if (irq_cfg[5] && irq_cfg[0] &&
            irq_prev_reg && !frame.irq_n)
          serializer_irq_out_n <= 1'b0;
      end
      if (isr_rd)
        serializer_irq_out_n <= 1'b1;
    end
  end
endmodule // dsctl_ser_model

// ===== bench/dsctl_top_tb.sv
`timescale 1ns/1ps
module dsctl_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, v, w;
  logic        pready, pslverr, fwd_valid, bc_data, bc_start, bc_bit_en;
  logic        power_down_n = 1'b0, clock_recovery_loop = 1'b0;
  logic        input_active = 1'b0, dual_lane = 1'b0;
  logic [7:0]  pix_freq_mhz = 8'd60, bc_ctrl_in = 8'h00, irq_cfg = 8'h21;
  logic        link_check_ok = 1'b1, strap_select_1 = 1'b1;
  logic        remote_irq_in_n = 1'b1, isr_rd = 1'b0;
  logic [3:0]  gpio_in = '0, dgpio_in = '0, gpio_src = '0;
  logic        frame_done, serializer_irq_out_n, mode18;
  logic        lock_out, lock_oe, pass_out, pass_oe, data_en, data_oe;
  logic [3:0]  gpio_out, gpio_oe, dgpio_out, dgpio_oe;
  logic [32:0] exp_q[$];
  int          n_fail = 0, n_checks = 0, cycles = 0, last_len = 0;
  integer      seed = 32'hde56;
  dsctl_pkg::dsctl_fwd_t fwd_symbol;
  dsctl_pkg::dsctl_bc_t  frame;
  dsctl_pkg::dsctl_csi_t csi_state;

  dsctl_top       u_dsctl_top (.*);
  dsctl_ser_model u_dsctl_ser_model (.*);

  always #25 pclk = ~pclk;

  // ***************
  // helpers
  // ***************
  task automatic check(input string what, input logic [32:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [9:0] ad(input logic [7:0] i);
    return {i, 2'b00};
  endfunction

  function automatic logic [3:0] crc_of(input logic [16:0] p);
    logic [3:0] c = '0;
    for (int k = 0; k < 17; k++) c[k % 4] ^= p[k];
    return c;
  endfunction

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [9:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic frames(input int n);
    repeat (n) begin
      last_len = 0;
      do begin
        @(posedge pclk);
        last_len++;
      end while (frame_done !== 1'b1);
    end
  endtask

  task end_test(input string name);
    $display("test %s finished", name);
  endtask

  // ***************
  // read result monitor and timeout
  // ***************
  always @(posedge pclk) begin
    cycles++;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check("prdata", {pslverr, prdata}, exp_q.pop_front());
    if (cycles == 20000) begin
      n_fail++;
      $display("timeout");
      test_done();
    end
  end

  // ***************
  // main sequence
  // ***************
  initial begin
    cyc(6);
    presetn <= 1'b1;
    rd(ad(dsctl_pkg::OUT_CFG_IDX), {25'h0, dsctl_pkg::OUT_CFG_RST});
    rd(ad(dsctl_pkg::PORT_SEL_IDX), {25'h0, dsctl_pkg::PORT_SEL_RST});
    rd(ad(dsctl_pkg::GPIO0_CFG_IDX), 33'h0);
    rd(ad(dsctl_pkg::CTRL_IDX), 33'h0);
    rd(10'h3fc, {1'b1, 32'h0});
    rd(10'h009, {1'b1, 32'h0});
    end_test("registers");
    v = $random(seed);
    w = $random(seed);
    apb(1'b1, ad(dsctl_pkg::PORT_SEL_IDX), 32'h3);
    apb(1'b1, ad(dsctl_pkg::GPIO21_CFG_IDX), {24'h0, v[7:0]});
    apb(1'b1, ad(dsctl_pkg::PORT_SEL_IDX), 32'h1);
    rd(ad(dsctl_pkg::GPIO21_CFG_IDX), {25'h0, v[7:0]});
    apb(1'b1, ad(dsctl_pkg::GPIO21_CFG_IDX), {24'h0, w[7:0]});
    apb(1'b1, ad(dsctl_pkg::PORT_SEL_IDX), 32'h2);
    rd(ad(dsctl_pkg::GPIO21_CFG_IDX), {25'h0, v[7:0]});
    rd(ad(dsctl_pkg::OUT_CFG_IDX), {25'h0, dsctl_pkg::OUT_CFG_RST});
    apb(1'b1, ad(dsctl_pkg::PORT_SEL_IDX), 32'h3);
    rd(ad(dsctl_pkg::GPIO21_CFG_IDX), {25'h0, v[7:0]});
    apb(1'b1, ad(dsctl_pkg::PORT_SEL_IDX), 32'h1);
    rd(ad(dsctl_pkg::GPIO21_CFG_IDX), {25'h0, w[7:0]});
    end_test("port select");
    check("oe", {lock_oe, pass_oe, data_oe, gpio_oe}, 7'h0);
    check("csi", csi_state, dsctl_pkg::CSI_OFF);
    power_down_n <= 1'b1;
    cyc(4);
    check("lock", lock_out, 1'b0);
    pix_freq_mhz <= 8'd97;
    clock_recovery_loop <= 1'b1;
    input_active <= 1'b1;
    cyc(4);
    check("lock", lock_out, 1'b0);
    pix_freq_mhz <= 8'd96;
    cyc(4);
    check("lock", {lock_out, lock_oe, pass_out}, 3'h7);
    check("csi", csi_state, dsctl_pkg::CSI_VALID);
    dual_lane <= 1'b1;
    pix_freq_mhz <= 8'd170;
    cyc(4);
    check("lock", lock_out, 1'b1);
    apb(1'b1, ad(dsctl_pkg::OUT_CFG_IDX), 32'h80);
    cyc(3);
    check("lock data", {lock_out, data_en}, 2'h0);
    check("csi", csi_state, dsctl_pkg::CSI_HS_ZERO);
    apb(1'b1, ad(dsctl_pkg::OUT_CFG_IDX), 32'h90);
    cyc(3);
    input_active <= 1'b0;
    cyc(3);
    link_check_ok <= 1'b0;
    cyc(3);
    check("pass", {pass_out, data_en}, 2'h2);
    input_active <= 1'b1;
    apb(1'b1, ad(dsctl_pkg::OUT_CFG_IDX), 32'h00);
    cyc(3);
    check("data", {data_oe, data_en, pass_out}, 3'h4);
    check("csi", csi_state, dsctl_pkg::CSI_HS_ZERO);
    apb(1'b1, ad(dsctl_pkg::OUT_CFG_IDX), 32'h10);
    cyc(3);
    check("oe", {data_oe, pass_oe}, 2'h0);
    check("csi", csi_state, dsctl_pkg::CSI_OFF);
    apb(1'b1, ad(dsctl_pkg::OUT_CFG_IDX), 32'h90);
    clock_recovery_loop <= 1'b0;
    cyc(3);
    check("lock", lock_out, 1'b0);
    clock_recovery_loop <= 1'b1;
    cyc(4);
    end_test("output states");
    gpio_src <= 4'($random(seed));
    gpio_in <= 4'($random(seed));
    bc_ctrl_in <= 8'($random(seed));
    remote_irq_in_n <= 1'b0;
    apb(1'b1, ad(dsctl_pkg::GPIO0_CFG_IDX), {28'h0, dsctl_pkg::GPIO_FWD_OUT});
    apb(1'b1, ad(dsctl_pkg::GPIO21_CFG_IDX), 32'h33);
    apb(1'b1, ad(dsctl_pkg::GPIO3_CFG_IDX), 32'h3);
    apb(1'b1, ad(dsctl_pkg::CTRL_IDX), 32'h1);
    frames(3);
    check("ctrl", frame.ctrl, bc_ctrl_in);
    check("gpio", frame.gpio[3:1], gpio_in[3:1]);
    check("crc", frame.crc, crc_of(frame[20:4]));
    check("irq", {frame.irq_n, serializer_irq_out_n}, 2'h0);
    check("fwd gpio", {gpio_oe[0], gpio_out[0]}, {1'b1, gpio_src[0]});
    check("mode18", mode18, 1'b1);
    check("fast len", last_len, dsctl_pkg::BC_BITS);
    isr_rd <= 1'b1;
    cyc(1);
    isr_rd <= 1'b0;
    frames(2);
    check("irq", serializer_irq_out_n, 1'b1);
    remote_irq_in_n <= 1'b1;
    frames(3);
    remote_irq_in_n <= 1'b0;
    frames(3);
    cyc(2);
    check("irq", serializer_irq_out_n, 1'b0);
    dgpio_in <= 4'($random(seed));
    apb(1'b1, ad(dsctl_pkg::PORT_SEL_IDX), 32'h2);
    apb(1'b1, ad(dsctl_pkg::GPIO0_CFG_IDX), {28'h0, dsctl_pkg::GPIO_BC_IN});
    apb(1'b1, ad(dsctl_pkg::GPIO3_CFG_IDX), {28'h0, dsctl_pkg::GPIO_FWD_OUT});
    frames(3);
    check("dgpio", frame.dgpio[0], dgpio_in[0]);
    check("dgpio out", {dgpio_oe[3], dgpio_out[3]}, {1'b1, ~gpio_src[3]});
    strap_select_1 <= 1'b0;
    bc_ctrl_in <= 8'($random(seed));
    frames(3);
    check("ctrl", frame.ctrl, bc_ctrl_in);
    check("slow len", last_len, dsctl_pkg::BC_BITS *
          (dsctl_pkg::PCLK_MHZ / dsctl_pkg::BC_SLOW_MBPS));
    end_test("gpio and interrupt");
    cyc(2);
    test_done();
  end
endmodule // dsctl_top_tb
